/* File: logic/rcd_countdown_timer.sv */
`timescale 1ns/1ps
`include "rcd_defines.svh"

// Function
// - 8-bit counter, value 10h, config 11h
// - config bits 4:3 pick source clock
// - period equals count over source frequency
// - zero count stops; 1..255 count down
// - expiry from one sets flag, reloads
// - new count written takes effect immediately
// - config bit 2 starts counting
// - flag sticky until cleared by flag_clr
// - config bit 1 gates the interrupt
// - config bit 0 selects level or pulse
// - pulse width depends on source, count
// - flag and interrupt assert together
// - reads return live count; read twice
// - slow sources take offset correction pulses
module rcd_countdown_timer
  import rcd_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       osc_tick,
  input  wire logic       corr_shorten,
  input  wire logic       corr_lengthen,
  input  rcd_wr_t         reg_wr,
  input  wire logic       rd_en,
  input  wire logic [4:0] rd_addr,
  output logic      [7:0] rd_data,
  input  wire logic       flag_clr,
  output logic            countdown_flag,
  output logic            timer_irq
);

  rcd_ticks_t  ticks;
  rcd_state_t  state_r,  state_nxt;
  logic [7:0]  reload_r, reload_nxt;
  logic [7:0]  cnt_r,    cnt_nxt;
  logic [4:0]  cfg_r,    cfg_nxt;
  logic        skip_r,   skip_nxt;
  logic        flag_r,   flag_nxt;
  logic [7:0]  pw_r,     pw_nxt;
  logic [7:0]  rdat_r,   rdat_nxt;
  logic        src_tick, expire, run_gate_bit, wr_value, wr_config;
  rcd_src_t    source_clock_select;

  // pulse width in 8192 Hz ticks for a source and reload count
  function automatic logic [7:0] pulse_width(input rcd_src_t sel, input logic [7:0] t);
    case (sel)
      RCD_SRC_4096: pulse_width = (t == 8'h01) ? `RCD_PW_4096_ONE : `RCD_PW_4096;
      RCD_SRC_64:   pulse_width = (t == 8'h01) ? `RCD_PW_64_ONE : `RCD_PW_64;
      default:      pulse_width = `RCD_PW_SLOW;
    endcase
  endfunction

  // address match shared by the write and read paths
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  // ****************************************
  // source clocks
  // ****************************************
  rcd_prescaler u_prescaler (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .osc_tick      (osc_tick),
    .corr_shorten  (corr_shorten),
    .corr_lengthen (corr_lengthen),
    .ticks         (ticks)
  );

  assign source_clock_select = rcd_src_t'(cfg_r[`RCD_SEL_HI:`RCD_SEL_LO]);
  assign run_gate_bit        = cfg_r[`RCD_RUN_BIT];
  assign wr_value            = reg_wr.en && hit(reg_wr.addr, `RCD_OFS_VALUE);
  assign wr_config           = reg_wr.en && hit(reg_wr.addr, `RCD_OFS_CONFIG);

  // source mux; the prescaler runs free so the first period has up to one tick of slack
  always_comb begin
    case (source_clock_select)
      RCD_SRC_4096: src_tick = ticks.t4096;
      RCD_SRC_64:   src_tick = ticks.t64;
      RCD_SRC_1:    src_tick = ticks.t1;
      default:      src_tick = ticks.t60th;
    endcase
  end

  // ****************************************
  // counter and registers
  // ****************************************
  // the gate is checked too, so a stop in flight never sets the flag without a reload
  assign expire = (state_r == RCD_RUNNING) && run_gate_bit && !skip_r && src_tick
                  && (cnt_r == 8'h01) && !wr_value;

  // a write of the count wins over a tick in the same cycle
  // fast sources swallow the first tick after a start, so the first period spans T to T+1
  always_comb begin
    state_nxt  = state_r;
    reload_nxt = reload_r;
    cnt_nxt    = cnt_r;
    cfg_nxt    = cfg_r;
    skip_nxt   = skip_r;
    case (state_r)
      RCD_STOPPED: begin
        if (run_gate_bit) begin
          state_nxt = RCD_RUNNING;
          cnt_nxt   = reload_r;
          skip_nxt  = !cfg_r[`RCD_SEL_HI];
        end
      end
      RCD_RUNNING: begin
        if (!run_gate_bit) begin
          state_nxt = RCD_STOPPED;
        end else if (expire) begin
          cnt_nxt = reload_r;
        end else if (src_tick && skip_r) begin
          skip_nxt = 1'b0;
        end else if (src_tick && cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: state_nxt = RCD_STOPPED;
    endcase
    if (wr_value) begin
      reload_nxt = reg_wr.data;
      cnt_nxt    = reg_wr.data;
    end
    if (wr_config) begin
      cfg_nxt = reg_wr.data[4:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r  <= RCD_STOPPED;
      reload_r <= `RCD_VALUE_RST;
      cnt_r    <= `RCD_VALUE_RST;
      cfg_r    <= `RCD_CONFIG_RST;
      skip_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      reload_r <= reload_nxt;
      cnt_r    <= cnt_nxt;
      cfg_r    <= cfg_nxt;
      skip_r   <= skip_nxt;
    end
  end

  // ****************************************
  // flag, interrupt pulse and read-back
  // ****************************************
  // set beats clear so an expiry in the clearing cycle is never lost
  always_comb begin
    flag_nxt = (flag_r && !flag_clr) || expire;
    pw_nxt   = pw_r;
    if (expire) begin
      pw_nxt = pulse_width(source_clock_select, reload_r);
    end else if (ticks.t8192 && pw_r != 8'h00) begin
      pw_nxt = pw_r - 8'h01;
    end
    rdat_nxt = rdat_r;
    if (rd_en) begin
      if (hit(rd_addr, `RCD_OFS_VALUE)) begin
        rdat_nxt = cnt_r;
      end else if (hit(rd_addr, `RCD_OFS_CONFIG)) begin
        rdat_nxt = {3'b000, cfg_r};
      end else begin
        rdat_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
      pw_r   <= 8'h00;
      rdat_r <= 8'h00;
    end else begin
      flag_r <= flag_nxt;
      pw_r   <= pw_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign countdown_flag = flag_r;
  assign rd_data        = rdat_r;

  // both modes read registers that load on the same edge, so flag and irq rise together
  always_comb begin
    if (!cfg_r[`RCD_IRQ_GATE_BIT]) begin
      timer_irq = 1'b0;
    end else if (cfg_r[`RCD_PULSE_BIT]) begin
      timer_irq = (pw_r != 8'h00);
    end else begin
      timer_irq = flag_r;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_flag_on_expire;
    @(posedge clk_sys) disable iff (rst)
    expire |=> countdown_flag;
  endproperty
  a_flag_on_expire: assert property (p_flag_on_expire) else $error("flag not set");

  property p_reload;
    @(posedge clk_sys) disable iff (rst)
    expire |=> (cnt_r == $past(reload_r));
  endproperty
  a_reload: assert property (p_reload) else $error("count not reloaded");

  property p_zero_stops;
    @(posedge clk_sys) disable iff (rst)
    (cnt_r == 8'h00 && reload_r == 8'h00 && !wr_value) |=> (cnt_r == 8'h00) && !$rose(flag_r);
  endproperty
  a_zero_stops: assert property (p_zero_stops) else $error("zero count ran");

  property p_decrement;
    @(posedge clk_sys) disable iff (rst)
    (state_r == RCD_RUNNING && run_gate_bit && !skip_r && src_tick && cnt_r > 8'h01 && !wr_value)
      |=> (cnt_r == $past(cnt_r) - 8'h01);
  endproperty
  a_decrement: assert property (p_decrement) else $error("bad decrement");

  property p_write_now;
    @(posedge clk_sys) disable iff (rst)
    wr_value |=> (cnt_r == $past(reg_wr.data)) && (reload_r == cnt_r);
  endproperty
  a_write_now: assert property (p_write_now) else $error("write not immediate");

  property p_start;
    @(posedge clk_sys) disable iff (rst)
    (state_r == RCD_STOPPED && run_gate_bit && !wr_value) |=> (cnt_r == reload_r);
  endproperty
  a_start: assert property (p_start) else $error("start did not load");

  property p_sticky;
    @(posedge clk_sys) disable iff (rst)
    (countdown_flag && !flag_clr) |=> countdown_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");

  property p_gate;
    @(posedge clk_sys) disable iff (rst)
    !cfg_r[`RCD_IRQ_GATE_BIT] |-> !timer_irq;
  endproperty
  a_gate: assert property (p_gate) else $error("irq while gated");

  property p_level;
    @(posedge clk_sys) disable iff (rst)
    (cfg_r[`RCD_IRQ_GATE_BIT] && !cfg_r[`RCD_PULSE_BIT]) |-> (timer_irq == countdown_flag);
  endproperty
  a_level: assert property (p_level) else $error("irq not tracking flag");

  property p_together;
    @(posedge clk_sys) disable iff (rst)
    (expire && !flag_r && cfg_r[`RCD_IRQ_GATE_BIT] && !wr_config)
      |=> (countdown_flag && timer_irq);
  endproperty
  a_together: assert property (p_together) else $error("flag and irq apart");

  property p_width_4096;
    @(posedge clk_sys) disable iff (rst)
    (expire && source_clock_select == RCD_SRC_4096 && reload_r > 8'h01)
      |=> (pw_r == 8'h02);
  endproperty
  a_width_4096: assert property (p_width_4096) else $error("bad pulse width");

  property p_read_live;
    @(posedge clk_sys) disable iff (rst)
    (rd_en && rd_addr == `RCD_OFS_VALUE) |=> (rd_data == $past(cnt_r));
  endproperty
  a_read_live: assert property (p_read_live) else $error("read not live");

  c_expire:  cover property (@(posedge clk_sys) disable iff (rst) expire);
  c_pulse:   cover property (@(posedge clk_sys) disable iff (rst)
                             $fell(timer_irq) && cfg_r[`RCD_PULSE_BIT]);
  c_clr_hit: cover property (@(posedge clk_sys) disable iff (rst) expire && flag_clr);
  c_slow:    cover property (@(posedge clk_sys) disable iff (rst)
                             expire && source_clock_select == RCD_SRC_1);

endmodule // rcd_countdown_timer

/* File: include/rcd_defines.svh */
`ifndef RCD_DEFINES_SVH
`define RCD_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define RCD_ADDR_W        5
`define RCD_OFS_VALUE     5'h10
`define RCD_OFS_CONFIG    5'h11
`define RCD_VALUE_RST     8'h00
`define RCD_CONFIG_RST    5'h18

// ****************************************
// configuration fields
// ****************************************
`define RCD_SEL_HI        4
`define RCD_SEL_LO        3
`define RCD_RUN_BIT       2
`define RCD_IRQ_GATE_BIT  1
`define RCD_PULSE_BIT     0

// ****************************************
// prescaler counts, in oscillator ticks, 64 Hz ticks and seconds
// ****************************************
`define RCD_OSC_HZ        32768
`define RCD_DIV_8192      2'h3
`define RCD_DIV_4096      3'h7
`define RCD_DIV_64        9'h1ff
`define RCD_SUB_PER_SEC   7'h40
`define RCD_SEC_PER_MIN   6'h3b

// ****************************************
// irq pulse widths, in 8192 Hz ticks
// ****************************************
`define RCD_PW_4096_ONE   8'h01
`define RCD_PW_4096       8'h02
`define RCD_PW_64_ONE     8'h40
`define RCD_PW_64         8'h80
`define RCD_PW_SLOW       8'h80

`endif

/* File: include/rcd_pkg.sv */
package rcd_pkg;

  // source clock choices, in field order
  typedef enum logic [1:0] {
    RCD_SRC_4096 = 2'h0,
    RCD_SRC_64   = 2'h1,
    RCD_SRC_1    = 2'h2,
    RCD_SRC_60TH = 2'h3
  } rcd_src_t;

  // register write strobe with its address and data
  typedef struct packed {
    logic       en;
    logic [4:0] addr;
    logic [7:0] data;
  } rcd_wr_t;

  // one-cycle ticks from the prescaler
  typedef struct packed {
    logic t8192;
    logic t4096;
    logic t64;
    logic t1;
    logic t60th;
  } rcd_ticks_t;

  // counter run state
  typedef enum logic {
    RCD_STOPPED,
    RCD_RUNNING
  } rcd_state_t;

endpackage

/* File: logic/rcd_prescaler.sv */
`timescale 1ns/1ps
`include "rcd_defines.svh"

module rcd_prescaler
  import rcd_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       osc_tick,
  input  wire logic       corr_shorten,
  input  wire logic       corr_lengthen,
  output rcd_ticks_t      ticks
);

  logic [14:0] div_r,  div_nxt;
  logic [5:0]  sub_r,  sub_nxt;
  logic [5:0]  sec_r,  sec_nxt;
  logic [6:0]  sub_sum;
  logic        t64, t1;

  // ****************************************
  // binary division of the oscillator
  // ****************************************
  assign t64 = osc_tick && (div_r[8:0] == `RCD_DIV_64);

  // offset correction only reaches the slow path, so the fast sources stay exact
  always_comb begin
    sub_sum = {1'b0, sub_r};
    if (t64 && !corr_lengthen) begin
      sub_sum = sub_sum + (corr_shorten ? 7'h02 : 7'h01);
    end else if (!t64 && corr_shorten) begin
      sub_sum = sub_sum + 7'h01;
    end
    t1      = (sub_sum >= `RCD_SUB_PER_SEC);
    div_nxt = osc_tick ? div_r + 15'h0001 : div_r;
    sub_nxt = t1 ? 6'(sub_sum - `RCD_SUB_PER_SEC) : sub_sum[5:0];
    sec_nxt = sec_r;
    if (t1) begin
      sec_nxt = (sec_r == `RCD_SEC_PER_MIN) ? 6'h00 : sec_r + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_r <= 15'h0000;
      sub_r <= 6'h00;
      sec_r <= 6'h00;
    end else begin
      div_r <= div_nxt;
      sub_r <= sub_nxt;
      sec_r <= sec_nxt;
    end
  end

  // tick outputs are one-cycle strobes
  assign ticks.t8192 = osc_tick && (div_r[1:0] == `RCD_DIV_8192);
  assign ticks.t4096 = osc_tick && (div_r[2:0] == `RCD_DIV_4096);
  assign ticks.t64   = t64;
  assign ticks.t1    = t1;
  assign ticks.t60th = t1 && (sec_r == `RCD_SEC_PER_MIN);

endmodule // rcd_prescaler

/* File: testbench/test_rcd_countdown_timer.sv */
`timescale 1ns/1ps
`include "rcd_defines.svh"

module test_rcd_countdown_timer
  import rcd_pkg::*;
;
  logic       clk_sys;
  logic       rst;
  logic       osc_tick;
  logic       corr_shorten;
  logic       corr_lengthen;
  logic       corr_en;
  rcd_wr_t    reg_wr;
  logic       rd_en;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;
  logic       flag_clr;
  logic       countdown_flag;
  logic       timer_irq;
  logic [7:0] got;
  logic [7:0] d;
  logic [1:0] osc_div;
  int         num_errors;
  int         checked;
  int         cyc;
  int         t0;
  int         t1;
  int         n;
  int         tv;
  logic [7:0] pcfg [4] = '{8'h0f, 8'h0f, 8'h07, 8'h07};
  int         pt   [4] = '{1, 2, 1, 2};

  rcd_countdown_timer uut (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .osc_tick       (osc_tick),
    .corr_shorten   (corr_shorten),
    .corr_lengthen  (corr_lengthen),
    .reg_wr         (reg_wr),
    .rd_en          (rd_en),
    .rd_addr        (rd_addr),
    .rd_data        (rd_data),
    .flag_clr       (flag_clr),
    .countdown_flag (countdown_flag),
    .timer_irq      (timer_irq)
  );

  // ****************************************
  // clock, oscillator ticks, correction noise
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // oscillator every 4 clocks keeps the 64 Hz cases short
  always @(posedge clk_sys) begin
    cyc           <= cyc + 1;
    osc_div       <= osc_div + 2'h1;
    osc_tick      <= (osc_div == 2'h3);
    corr_shorten  <= corr_en && ($urandom_range(15) == 0);
    corr_lengthen <= corr_en && ($urandom_range(15) == 0);
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // expected irq pulse in clocks; one 8192 Hz tick is 16 clocks with osc every 4
  function automatic int exp_pulse(input logic [7:0] cfg, input int t);
    int w;
    w = (cfg[4:3] == 2'h0) ? 1 : 64;
    if (t > 1 || cfg[4]) begin
      w = 2 * w;
    end
    exp_pulse = w * 16;
  endfunction

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= '{en: 1'b1, addr: a, data: v};
    @(posedge clk_sys);
    reg_wr.en <= 1'b0;
  endtask

  // read data lands one cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask

  // bounded wait for the flag; time stamp taken one step after the edge
  task automatic wait_flag(input int lim, output int at);
    int k;
    k = 0;
    #1;
    while (countdown_flag !== 1'b1 && k < lim) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check8("countdown_flag wait", 8'h01, {7'h00, countdown_flag});
    at = cyc;
  endtask

  task automatic clr;
    @(posedge clk_sys);
    flag_clr <= 1'b1;
    @(posedge clk_sys);
    flag_clr <= 1'b0;
    #1 check8("countdown_flag cleared", 8'h00, {7'h00, countdown_flag});
  endtask

  task automatic test_done;
    $display("errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog sized well above the expected run of about 20k cycles
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    test_done;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h1ccf_bf60));
    {rst, osc_tick, corr_shorten, corr_lengthen, corr_en} = 5'h1c;
    {rd_en, flag_clr, rd_addr, osc_div, cyc} = '0;
    reg_wr = '0;
    num_errors = 0;
    checked = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 check8("reset irq", 8'h00, {7'h00, timer_irq});
    rd(5'h10, got);
    check8("value reset", `RCD_VALUE_RST, got);
    rd(5'h11, got);
    check8("config reset", 8'h18, got);
    // random config bytes; upper bits must read zero, count 0 keeps it idle
    repeat (4) begin
      d = 8'($urandom);
      wr(5'h11, d);
      rd(5'h11, got);
      check8("config", {3'h0, d[4:0]}, got);
    end
    wr(5'h11, 8'h18);
    d = 8'($urandom_range(255, 1));
    wr(5'h10, d);
    wr(5'h05, 8'hff);
    rd(5'h05, got);
    check8("unmapped", 8'h00, got);
    rd(5'h10, got);
    check8("value", d, got);
    // exact periods at 4096 Hz with correction pulses running
    corr_en = 1'b1;
    repeat (3) begin
      tv = $urandom_range(4, 1);
      wr(5'h10, 8'(tv));
      wr(5'h11, 8'h04);
      wait_flag(200, t0);
      clr;
      wait_flag(200, t1);
      check8("period", 8'(tv * 32), 8'(t1 - t0));
      // just reloaded and no tick due for 32 clocks, so both reads see the full count
      rd(5'h10, got);
      rd(5'h10, d);
      check8("live count", 8'(tv), got);
      check8("live count again", got, d);
      wr(5'h11, 8'h18);
      clr;
    end
    corr_en = 1'b0;
    // level mode, then gate off with a sticky flag
    wr(5'h10, 8'h03);
    wr(5'h11, 8'h06);
    wait_flag(400, t0);
    check8("irq level", 8'h01, {7'h00, timer_irq});
    clr;
    check8("irq follows flag", 8'h00, {7'h00, timer_irq});
    wr(5'h11, 8'h04);
    wait_flag(400, t0);
    check8("irq gated", 8'h00, {7'h00, timer_irq});
    repeat (40) @(posedge clk_sys);
    #1 check8("flag sticky", 8'h01, {7'h00, countdown_flag});
    // a new count takes effect at once
    wr(5'h10, 8'hc8);
    clr;
    wr(5'h10, 8'h01);
    wait_flag(48, t0);
    // zero count stops the timer
    wr(5'h10, 8'h00);
    clr;
    repeat (300) @(posedge clk_sys);
    #1 check8("stopped flag", 8'h00, {7'h00, countdown_flag});
    rd(5'h10, got);
    check8("stopped count", 8'h00, got);
    // pulse widths for 64 Hz and 4096 Hz, counts one and two
    for (int i = 0; i < 4; i++) begin
      wr(5'h11, 8'h18);
      wr(5'h10, 8'(pt[i]));
      wr(5'h11, pcfg[i]);
      tv = pt[i] * (pcfg[i] == 8'h07 ? 32 : 2048) * 3 + 64;
      wait_flag(tv, t0);
      clr;
      wait_flag(tv, t1);
      check8("irq pulse start", 8'h01, {7'h00, timer_irq});
      n = 0;
      while (timer_irq === 1'b1 && n < 4000) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      t0 = exp_pulse(pcfg[i], pt[i]);
      checked++;
      if (n != t0) begin
        num_errors++;
        $display("unexpected pulse width: expected %0d clocks, seen %0d", t0, n);
      end
      clr;
    end
    wr(5'h11, 8'h18);
    test_done;
  end
endmodule // test_rcd_countdown_timer
